/* File: design/order_pkg.sv */
// Shared types and constants for the write ordering and barrier tracker
`default_nettype none
package order_pkg;
  // Data path sizes
  localparam int ADDR_W     = 4;              // Word address width
  localparam int DATA_W     = 16;             // Data word width
  localparam int TAG_W      = 2;              // Metadata tag, carries stream id
  localparam int MEM_WORDS  = 1 << ADDR_W;    // Backing store size
  // Depths and counts
  localparam int FIFO_DEPTH = 16;             // Command FIFO per stream
  localparam int CNT_W      = 4;              // Outstanding counter width
  localparam int WSLOTS     = 4;              // Pending writes in the unit
  localparam int RSLOTS     = 4;              // Pending reads in the unit
  localparam int NSTREAMS   = 2;              // Independent write streams

  // Virtual channel selector
  typedef enum logic [1:0] {
    AUTO_SELECT_CHANNEL = 2'h0,
    LOW_LATENCY_CHANNEL = 2'h1,
    HOST_LINK_CHANNEL_A = 2'h2,
    HOST_LINK_CHANNEL_B = 2'h3
  } channel_selector_t;

  // Request kinds
  typedef enum logic [1:0] {
    OP_READ              = 2'h0,
    OP_WRITE             = 2'h1,
    OP_WRITE_FENCE       = 2'h2
  } req_kind_t;

  // Kind of answer on the write response channel
  typedef enum logic {
    RESP_WRITE = 1'h0,
    RESP_FENCE = 1'h1
  } resp_kind_t;

  // One user command as queued per stream
  typedef struct packed {
    req_kind_t         kind;
    logic              barrier;
    channel_selector_t chan;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } cmd_t;

  localparam int CMD_W = $bits(cmd_t);        // Packed command width
endpackage
`default_nettype wire

/* File: design/host_req_if.sv */
// Request and response channels between accelerator and host interface unit
`default_nettype none
interface host_req_if (
  input wire logic mclk,
  input wire logic rst_n
);
  import order_pkg::*;
  // Request channel
  logic                  req_valid;
  req_kind_t             req_kind;
  channel_selector_t     req_chan;
  logic [ADDR_W-1:0]     req_addr;
  logic [DATA_W-1:0]     req_data;
  logic [TAG_W-1:0]      req_tag;
  logic                  wr_ready;   // Writes and fences may be taken
  logic                  rd_ready;   // Reads may be taken
  // Write response channel
  logic                  wresp_valid;
  resp_kind_t            wresp_kind;
  logic [TAG_W-1:0]      wresp_tag;
  // Read response channel
  logic                  rresp_valid;
  logic [TAG_W-1:0]      rresp_tag;
  channel_selector_t     rresp_chan;
  logic [DATA_W-1:0]     rresp_data;

  modport accel (
    input  mclk, rst_n, wr_ready, rd_ready, wresp_valid, wresp_kind, wresp_tag,
           rresp_valid, rresp_tag, rresp_chan, rresp_data,
    output req_valid, req_kind, req_chan, req_addr, req_data, req_tag
  );
  modport unit (
    input  mclk, rst_n, req_valid, req_kind, req_chan, req_addr, req_data, req_tag,
    output wr_ready, rd_ready, wresp_valid, wresp_kind, wresp_tag,
           rresp_valid, rresp_tag, rresp_chan, rresp_data
  );
endinterface
`default_nettype wire

/* File: design/host_interface_unit.sv */
// Host interface unit end: reorders requests, drains writes on a fence
// Operation
// RULE_01 - Writes after barrier wait prior responses
// RULE_02 - Counter up on write, down on response
// RULE_03 - Write response means local observability only
// RULE_04 - Counting barriers only on one physical channel
// RULE_05 - Per-stream trackers; barrier stalls one stream
// RULE_06 - Stream id travels in metadata tag
// RULE_07 - Unit reorders freely, no hazard detection
// RULE_08 - Same-channel writes ordered only after response
// RULE_09 - Different-channel writes carry no order
// RULE_10 - Auto-channel fence orders writes across channels
// RULE_11 - After fence, later writes stall until drained
// RULE_12 - Cross-channel reads may return out of order
// RULE_13 - Same-channel reads: last response is newest
// RULE_14 - Auto-channel reads steered to any physical channel
// RULE_15 - Accelerator resolves read-after-write itself
// RULE_16 - No read-after-write reliance across channels
// RULE_17 - Write after read waits read response
// RULE_18 - Fence answered on write response channel
// RULE_19 - Fence never blocks later reads
// RULE_20 - Outstanding counters never wrap
`default_nettype none
module host_interface_unit (
  // Link to the accelerator
  host_req_if.unit                          hi,
  // Clock and reset
  input  wire logic                         mclk,
  input  wire logic                         rst_n,
  // Processor view of memory and fence status
  input  wire logic [order_pkg::ADDR_W-1:0] peek_addr,
  output logic      [order_pkg::DATA_W-1:0] peek_data,
  output logic                              fence_busy
);
  import order_pkg::*;

  // Fence drain states
  typedef enum logic [1:0] {
    FN_OPEN  = 2'b01,
    FN_DRAIN = 2'b10
  } fence_state_t;

  localparam int WP_W = $clog2(WSLOTS);
  localparam int RP_W = $clog2(RSLOTS);

  // Backing store and pending tables
  logic [DATA_W-1:0]  mem        [MEM_WORDS];   // Committed memory
  logic [DATA_W-1:0]  next_mem   [MEM_WORDS];
  logic [WSLOTS-1:0]  wv, next_wv;              // Pending write valid
  logic [ADDR_W-1:0]  waddr      [WSLOTS];
  logic [ADDR_W-1:0]  next_waddr [WSLOTS];
  logic [DATA_W-1:0]  wdata      [WSLOTS];
  logic [DATA_W-1:0]  next_wdata [WSLOTS];
  logic [TAG_W-1:0]   wtag       [WSLOTS];
  logic [TAG_W-1:0]   next_wtag  [WSLOTS];
  logic [RSLOTS-1:0]  rv, next_rv;              // Pending read valid
  logic [ADDR_W-1:0]  raddr      [RSLOTS];
  logic [ADDR_W-1:0]  next_raddr [RSLOTS];
  logic [TAG_W-1:0]   rtag       [RSLOTS];
  logic [TAG_W-1:0]   next_rtag  [RSLOTS];
  channel_selector_t  rchan      [RSLOTS];      // Physical channel used
  channel_selector_t  next_rchan [RSLOTS];
  // Scan pointers, steering and fence drain state
  logic [WP_W-1:0]    wptr, next_wptr;          // Write commit scan
  logic [RP_W-1:0]    rptr, next_rptr;          // Read return scan
  channel_selector_t  steer, next_steer;        // Next auto-channel target
  fence_state_t       fstate, next_fstate;
  logic [TAG_W-1:0]   ftag, next_ftag;          // Tag of fence in drain
  // Registered outputs
  logic               next_wr_ready, next_rd_ready;
  logic               next_wresp_valid;
  resp_kind_t         next_wresp_kind;
  logic [TAG_W-1:0]   next_wresp_tag;
  logic               next_rresp_valid;
  logic [TAG_W-1:0]   next_rresp_tag;
  channel_selector_t  next_rresp_chan;
  logic [DATA_W-1:0]  next_rresp_data;

  // Lowest clear bit of a valid vector
  function automatic int first_free(input logic [7:0] v, input int n);
    int r;
    r = 0;
    for (int i = n - 1; i >= 0; i--) begin
      if (!v[i]) begin
        r = i;
      end
    end
    return r;
  endfunction

  // Next state of tables, fence drain and response registers
  always_comb begin
    int  slot;
    logic wr_take;
    logic rd_take;
    slot          = 0;
    next_mem      = mem;
    next_wv       = wv;
    next_waddr    = waddr;
    next_wdata    = wdata;
    next_wtag     = wtag;
    next_rv       = rv;
    next_raddr    = raddr;
    next_rtag     = rtag;
    next_rchan    = rchan;
    next_wptr     = wptr + 1'b1;            // Scan rotates every cycle
    next_rptr     = rptr + 1'b1;
    next_steer    = steer;
    next_fstate   = fstate;
    next_ftag     = ftag;
    next_wresp_valid = 1'b0;
    next_wresp_kind  = RESP_WRITE;
    next_wresp_tag   = '0;
    next_rresp_valid = 1'b0;
    next_rresp_tag   = '0;
    next_rresp_chan  = LOW_LATENCY_CHANNEL;
    next_rresp_data  = '0;
    wr_take = hi.req_valid && hi.wr_ready && (hi.req_kind != OP_READ);
    rd_take = hi.req_valid && hi.rd_ready && (hi.req_kind == OP_READ);

    // Drained fence answers; otherwise commit whichever slot the scan hits
    if ((fstate == FN_DRAIN) && (wv == '0)) begin
      next_wresp_valid = 1'b1;              // [RULE_18]
      next_wresp_kind  = RESP_FENCE;        // [RULE_18]
      next_wresp_tag   = ftag;
      next_fstate      = FN_OPEN;
    end else if (wv[wptr]) begin
      // Scan order ignores age and address, so overlapping writes may swap
      next_mem[waddr[wptr]] = wdata[wptr]; // [RULE_07] [RULE_08] [RULE_09]
      next_wv[wptr]    = 1'b0;
      next_wresp_valid = 1'b1;              // Local commit only [RULE_03]
      next_wresp_kind  = RESP_WRITE;
      next_wresp_tag   = wtag[wptr];
    end

    // Reads sample memory when returned, so same channel ends on newest data
    if (rv[rptr]) begin
      next_rv[rptr]    = 1'b0;
      next_rresp_valid = 1'b1;
      next_rresp_tag   = rtag[rptr];
      next_rresp_chan  = rchan[rptr];
      next_rresp_data  = mem[raddr[rptr]];  // [RULE_13] [RULE_12]
    end

    // Accept a write or a fence
    if (wr_take) begin
      if (hi.req_kind == OP_WRITE) begin
        slot = first_free(8'(wv), WSLOTS);
        next_wv[slot]    = 1'b1;
        next_waddr[slot] = hi.req_addr;
        next_wdata[slot] = hi.req_data;
        next_wtag[slot]  = hi.req_tag;
      end else begin
        // Every channel drains, so a fence is always a broadcast
        next_fstate = FN_DRAIN;             // [RULE_10] [RULE_11]
        next_ftag   = hi.req_tag;
      end
    end

    // Accept a read; auto-channel reads go to a rotating physical channel
    if (rd_take) begin
      slot = first_free(8'(rv), RSLOTS);
      next_rv[slot]    = 1'b1;
      next_raddr[slot] = hi.req_addr;
      next_rtag[slot]  = hi.req_tag;
      if (hi.req_chan == AUTO_SELECT_CHANNEL) begin
        next_rchan[slot] = steer;           // [RULE_14]
        next_steer = (steer == HOST_LINK_CHANNEL_B) ? LOW_LATENCY_CHANNEL
                                                    : channel_selector_t'(steer + 2'h1);
      end else begin
        next_rchan[slot] = hi.req_chan;
      end
    end

    // Readiness from the next state; fence only closes the write side
    next_wr_ready = (next_fstate == FN_OPEN) && !(&next_wv); // [RULE_11]
    next_rd_ready = !(&next_rv);                             // [RULE_19]
  end

  // Register everything
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < MEM_WORDS; i++) begin
        mem[i] <= '0;
      end
      for (int i = 0; i < WSLOTS; i++) begin
        waddr[i] <= '0;
        wdata[i] <= '0;
        wtag[i]  <= '0;
      end
      for (int i = 0; i < RSLOTS; i++) begin
        raddr[i] <= '0;
        rtag[i]  <= '0;
        rchan[i] <= LOW_LATENCY_CHANNEL;
      end
      wv             <= '0;
      rv             <= '0;
      wptr           <= '0;
      rptr           <= '0;
      steer          <= LOW_LATENCY_CHANNEL;
      fstate         <= FN_OPEN;
      ftag           <= '0;
      hi.wr_ready    <= 1'b0;
      hi.rd_ready    <= 1'b0;
      hi.wresp_valid <= 1'b0;
      hi.wresp_kind  <= RESP_WRITE;
      hi.wresp_tag   <= '0;
      hi.rresp_valid <= 1'b0;
      hi.rresp_tag   <= '0;
      hi.rresp_chan  <= LOW_LATENCY_CHANNEL;
      hi.rresp_data  <= '0;
      peek_data      <= '0;
      fence_busy     <= 1'b0;
    end else begin
      mem            <= next_mem;
      waddr          <= next_waddr;
      wdata          <= next_wdata;
      wtag           <= next_wtag;
      raddr          <= next_raddr;
      rtag           <= next_rtag;
      rchan          <= next_rchan;
      wv             <= next_wv;
      rv             <= next_rv;
      wptr           <= next_wptr;
      rptr           <= next_rptr;
      steer          <= next_steer;
      fstate         <= next_fstate;
      ftag           <= next_ftag;
      hi.wr_ready    <= next_wr_ready;
      hi.rd_ready    <= next_rd_ready;
      hi.wresp_valid <= next_wresp_valid;
      hi.wresp_kind  <= next_wresp_kind;
      hi.wresp_tag   <= next_wresp_tag;
      hi.rresp_valid <= next_rresp_valid;
      hi.rresp_tag   <= next_rresp_tag;
      hi.rresp_chan  <= next_rresp_chan;
      hi.rresp_data  <= next_rresp_data;
      peek_data      <= mem[peek_addr];
      fence_busy     <= (next_fstate == FN_DRAIN);
    end
  end
endmodule
`default_nettype wire

/* File: design/accelerator_function.sv */
// Accelerator end: per-stream command FIFOs, barrier tracking, fence issue
`default_nettype none
module stream_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rst_n,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] store [DEPTH];          // Flip-flop storage
  logic [PW-1:0]    wp, next_wp;            // Write index
  logic [PW-1:0]    rp, next_rp;            // Read index
  logic [CW-1:0]    count, next_count;      // Words held
  logic             push, pop, next_in_ready;

  assign out_valid = (count != '0);
  assign out_data  = store[rp];

  // Pointer and count update
  always_comb begin
    push = in_valid && in_ready;
    pop  = out_valid && out_ready;
    next_wp = push ? ((wp == PW'(DEPTH - 1)) ? '0 : wp + 1'b1) : wp;
    next_rp = pop ? ((rp == PW'(DEPTH - 1)) ? '0 : rp + 1'b1) : rp;
    next_count = count + CW'(push) - CW'(pop);
    next_in_ready = (next_count != CW'(DEPTH)); // Registered, so full is exact
  end

  // Register state; storage written on push only
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wp       <= '0;
      rp       <= '0;
      count    <= '0;
      in_ready <= 1'b0;
    end else begin
      wp       <= next_wp;
      rp       <= next_rp;
      count    <= next_count;
      in_ready <= next_in_ready;
      if (push) begin
        store[wp] <= in_data;
      end
    end
  end
endmodule

module accelerator_function #(
  parameter int NS    = order_pkg::NSTREAMS,
  parameter int CNTW  = order_pkg::CNT_W,
  parameter int FDEPTH = order_pkg::FIFO_DEPTH
) (
  // Link to the host interface unit
  host_req_if.accel                    hi,
  // Clock and reset
  input  wire logic                    mclk,
  input  wire logic                    rst_n,
  // Per-stream command push
  input  wire logic                    cmd_valid [NS],
  output logic                         cmd_ready [NS],
  input  wire order_pkg::cmd_t         cmd_word  [NS],
  // Read data back to the user
  output logic                         rdata_valid,
  output logic [order_pkg::DATA_W-1:0] rdata,
  output logic [order_pkg::TAG_W-1:0]  rdata_stream,
  // Status
  output logic [NS-1:0]                stream_stalled
);
  import order_pkg::*;

  // Per-stream barrier states
  typedef enum logic [2:0] {
    S_RUN        = 3'b001,
    S_FENCE_SENT = 3'b010,
    S_FENCED     = 3'b100
  } stream_state_t;

  localparam int SW = (NS > 1) ? $clog2(NS) : 1;
  localparam logic [CNTW-1:0] CNT_MAX = '1;

  // Per-stream tracking
  logic [CNTW-1:0]   wcnt [NS]; // Writes in flight
  logic [CNTW-1:0]   next_wcnt [NS];
  logic [CNTW-1:0]   rcnt [NS]; // Reads in flight
  logic [CNTW-1:0]   next_rcnt [NS];
  channel_selector_t last_chan [NS]; // Channel of last write
  channel_selector_t next_last_chan [NS];
  stream_state_t     st [NS];
  stream_state_t     next_st [NS];
  logic [SW-1:0]     rr, next_rr; // Round-robin start
  // FIFO heads
  logic              head_v [NS];
  cmd_t              head [NS];
  logic              pop [NS];
  // Decision terms
  logic [NS-1:0]     fence_want, go, want;
  // Registered request outputs
  logic              next_req_valid;
  req_kind_t         next_req_kind;
  channel_selector_t next_req_chan;
  logic [ADDR_W-1:0] next_req_addr;
  logic [DATA_W-1:0] next_req_data;
  logic [TAG_W-1:0]  next_req_tag;

  // Counter step; the room check keeps it from wrapping
  function automatic logic [CNTW-1:0] step(input logic [CNTW-1:0] c, input logic up, input logic dn);
    return c + CNTW'(up) - CNTW'(dn);
  endfunction

  // One command FIFO per stream keeps barriers from blocking others
  for (genvar s = 0; s < NS; s++) begin : g_fifo
    stream_fifo #(.WIDTH(CMD_W), .DEPTH(FDEPTH)) u_fifo (
      .mclk      (mclk),
      .rst_n     (rst_n),
      .in_valid  (cmd_valid[s]),
      .in_ready  (cmd_ready[s]),
      .in_data   (cmd_word[s]),
      .out_valid (head_v[s]),
      .out_ready (pop[s]),
      .out_data  (head[s])
    );
  end

  // Per-stream eligibility
  always_comb begin
    logic need_fence;
    logic clear;
    logic room;
    need_fence = 1'b0;
    clear      = 1'b0;
    room       = 1'b0;
    for (int s = 0; s < NS; s++) begin
      // Auto or changed channel cannot rely on counting alone
      need_fence = head[s].barrier && ((head[s].chan == AUTO_SELECT_CHANNEL) ||
                   (head[s].chan != last_chan[s])); // [RULE_04] [RULE_10] [RULE_16]
      // Prior writes and reads of this stream all answered
      clear = (wcnt[s] == '0) && (rcnt[s] == '0); // [RULE_01] [RULE_15] [RULE_17]
      room  = (head[s].kind == OP_READ) ? (rcnt[s] != CNT_MAX)
                                        : (wcnt[s] != CNT_MAX); // [RULE_20]
      fence_want[s] = head_v[s] && need_fence && (st[s] == S_RUN);
      go[s] = head_v[s] && (st[s] != S_FENCE_SENT) && room &&
              (!head[s].barrier || (clear && (!need_fence || (st[s] == S_FENCED)))); // [RULE_05]
      want[s] = fence_want[s] || go[s];
    end
  end

  // Arbitration, request register and tracker update
  always_comb begin
    logic slot_free;
    logic found;
    int   sel;
    int   idx;
    slot_free = !hi.req_valid ||
                ((hi.req_kind == OP_READ) ? hi.rd_ready : hi.wr_ready);
    found = 1'b0;
    sel   = 0;
    idx   = 0;
    next_rr        = rr;
    next_st        = st;
    next_last_chan = last_chan;
    next_req_valid = hi.req_valid && !slot_free;  // Hold until taken
    next_req_kind  = hi.req_kind;
    next_req_chan  = hi.req_chan;
    next_req_addr  = hi.req_addr;
    next_req_data  = hi.req_data;
    next_req_tag   = hi.req_tag;
    for (int s = 0; s < NS; s++) begin
      pop[s] = 1'b0;
    end
    for (int k = 0; k < NS; k++) begin
      idx = (int'(rr) + k) % NS;
      if (!found && want[idx]) begin
        found = 1'b1;
        sel   = idx;
      end
    end
    if (slot_free && found) begin
      next_req_valid = 1'b1;
      next_req_tag   = TAG_W'(sel); // Stream id in tag [RULE_06]
      next_rr        = SW'((sel + 1) % NS);
      if (fence_want[sel]) begin
        next_req_kind = OP_WRITE_FENCE; // [RULE_10]
        next_req_chan = AUTO_SELECT_CHANNEL;
        next_st[sel]  = S_FENCE_SENT;
      end else begin
        pop[sel]      = 1'b1;
        next_req_kind = head[sel].kind;
        next_req_chan = head[sel].chan;
        next_req_addr = head[sel].addr;
        next_req_data = head[sel].data;
        next_st[sel]  = S_RUN;
        if (head[sel].kind == OP_WRITE) begin
          next_last_chan[sel] = head[sel].chan;
        end
      end
    end
    // Count on issue, uncount on the matching response
    for (int s = 0; s < NS; s++) begin
      next_wcnt[s] = step(wcnt[s],
        pop[s] && (head[s].kind == OP_WRITE),
        hi.wresp_valid && (hi.wresp_kind == RESP_WRITE) && (hi.wresp_tag == TAG_W'(s))); // [RULE_02]
      next_rcnt[s] = step(rcnt[s],
        pop[s] && (head[s].kind == OP_READ),
        hi.rresp_valid && (hi.rresp_tag == TAG_W'(s)));
      if (hi.wresp_valid && (hi.wresp_kind == RESP_FENCE) &&
          (hi.wresp_tag == TAG_W'(s)) && (st[s] == S_FENCE_SENT)) begin
        next_st[s] = S_FENCED; // [RULE_10]
      end
    end
  end

  // Register state and outputs
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int s = 0; s < NS; s++) begin
        wcnt[s]      <= '0;
        rcnt[s]      <= '0;
        last_chan[s] <= AUTO_SELECT_CHANNEL;
        st[s]        <= S_RUN;
      end
      rr             <= '0;
      hi.req_valid   <= 1'b0;
      hi.req_kind    <= OP_READ;
      hi.req_chan    <= AUTO_SELECT_CHANNEL;
      hi.req_addr    <= '0;
      hi.req_data    <= '0;
      hi.req_tag     <= '0;
      rdata_valid    <= 1'b0;
      rdata          <= '0;
      rdata_stream   <= '0;
      stream_stalled <= '0;
    end else begin
      wcnt           <= next_wcnt;
      rcnt           <= next_rcnt;
      last_chan      <= next_last_chan;
      st             <= next_st;
      rr             <= next_rr;
      hi.req_valid   <= next_req_valid;
      hi.req_kind    <= next_req_kind;
      hi.req_chan    <= next_req_chan;
      hi.req_addr    <= next_req_addr;
      hi.req_data    <= next_req_data;
      hi.req_tag     <= next_req_tag;
      rdata_valid    <= hi.rresp_valid;
      rdata          <= hi.rresp_data;
      rdata_stream   <= hi.rresp_tag;
      for (int s = 0; s < NS; s++) begin
        stream_stalled[s] <= head_v[s] && !want[s];
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb/order_properties.sv */
// Concurrent checks on the link between accelerator and host interface unit
`default_nettype none
module order_properties (
  // Clock and reset
  input wire logic                          mclk,
  input wire logic                          rst_n,
  // Request channel
  input wire logic                          req_valid,
  input wire order_pkg::req_kind_t          req_kind,
  input wire logic [order_pkg::ADDR_W-1:0]  req_addr,
  input wire logic                          wr_ready,
  input wire logic                          rd_ready,
  // Response channels
  input wire logic                          wresp_valid,
  input wire order_pkg::resp_kind_t         wresp_kind,
  input wire logic [order_pkg::TAG_W-1:0]   wresp_tag,
  input wire logic                          rresp_valid,
  input wire order_pkg::channel_selector_t  rresp_chan
);
  import order_pkg::*;
  logic [3:0] wcnt;        // Writes taken, not yet answered
  logic       fence_open;  // Fence taken, answer still due
  logic       fence_take;  // Fence taken this cycle
  logic       fence_ans;   // Fence answered this cycle
  assign fence_take = req_valid && wr_ready && req_kind == OP_WRITE_FENCE;
  assign fence_ans  = wresp_valid && wresp_kind == RESP_FENCE;
  // Clear beats set on the fence flag; the write count adds and subtracts in one step
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wcnt <= 4'h0;
      fence_open <= 1'b0;
    end else begin
      wcnt <= wcnt + 4'(req_valid && wr_ready && req_kind == OP_WRITE) - 4'(wresp_valid && wresp_kind == RESP_WRITE);
      fence_open <= (fence_open || fence_take) && !fence_ans;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  hold_req_a:
    assert property (req_valid && !(req_kind == OP_READ ? rd_ready : wr_ready) |=> req_valid && $stable(req_kind)
      && $stable(req_addr)) else $error("request changed before taken");
  fence_stall_a:
    assert property (fence_take |=> !wr_ready) else $error("writes open after fence");
  fence_answer_a:
    assert property (fence_take |-> ##[1:300] fence_ans) else $error("no fence answer");
  no_pass_a:
    assert property (fence_open && !fence_ans |-> !(req_valid && wr_ready && req_kind != OP_READ))
      else $error("write passed fence");
  fence_drained_a:
    assert property (fence_ans |-> wcnt == 4'h0) else $error("fence answered early");
  wresp_count_a:
    assert property (wresp_valid && wresp_kind == RESP_WRITE |-> wcnt != 4'h0) else $error("stray write answer");
  wcnt_cap_a:
    assert property (wcnt <= 4'(WSLOTS + 1)) else $error("too many writes pending");
  phys_chan_a:
    assert property (rresp_valid |-> rresp_chan != AUTO_SELECT_CHANNEL) else $error("read on no channel");
  tag_range_a:
    assert property (wresp_valid |-> wresp_tag < 2'(NSTREAMS)) else $error("bad stream tag");
  cover property (fence_open && req_valid && rd_ready && req_kind == OP_READ);
  cover property (fence_ans);
  cover property (rresp_valid && !wr_ready);
endmodule
`default_nettype wire

/* File: tb/write_order_barrier_tracker_tb.sv */
// Self-checking bench for the accelerator and host interface unit pair
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin failures++; \
  $display("mismatch t=%0t got=%0h exp=%0h", $time, a, b); end end
module write_order_barrier_tracker_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import order_pkg::*;
  logic        mclk = 1'b0;   // Bench clock
  logic        rst_n = 1'b0;  // Reset, active low
  logic        cmd_valid [2]; // Per-stream push
  logic        cmd_ready [2]; // Queue not full
  cmd_t        cmd_word [2];  // Per-stream command
  logic        rdata_valid;   // Read answer pulse
  logic [15:0] rdata;         // Read data
  logic [1:0]  rdata_stream;  // Stream of the read
  logic [1:0]  stalled;       // Stream stall flags
  logic [3:0]  peek_addr;     // Memory view address
  logic [15:0] peek_data;     // Memory view data
  logic        fence_busy;    // Fence in progress
  logic [17:0] got;           // Last read, stream and data
  int          nrd = 0;       // Reads seen
  int          refused = 0;   // Cycles a push was refused
  int          failures = 0;
  int          samples_checked = 0;
  always #25 mclk = ~mclk;
  host_req_if host_req_if_i (.mclk(mclk), .rst_n(rst_n));
  host_interface_unit host_interface_unit_i (.hi(host_req_if_i.unit), .mclk, .rst_n,
    .peek_addr, .peek_data, .fence_busy);
  accelerator_function accelerator_function_i (.hi(host_req_if_i.accel), .mclk, .rst_n,
    .cmd_valid, .cmd_ready, .cmd_word, .rdata_valid, .rdata, .rdata_stream, .stream_stalled(stalled));
  order_properties order_properties_i (.mclk, .rst_n, .req_valid(host_req_if_i.req_valid),
    .req_kind(host_req_if_i.req_kind), .req_addr(host_req_if_i.req_addr), .wr_ready(host_req_if_i.wr_ready),
    .rd_ready(host_req_if_i.rd_ready), .wresp_valid(host_req_if_i.wresp_valid),
    .wresp_kind(host_req_if_i.wresp_kind), .wresp_tag(host_req_if_i.wresp_tag),
    .rresp_valid(host_req_if_i.rresp_valid), .rresp_chan(host_req_if_i.rresp_chan));
  // Catch the one-cycle read pulse whenever it comes
  always @(posedge mclk) if (rdata_valid === 1'b1) begin
    got <= {rdata_stream, rdata};
    nrd <= nrd + 1;
  end
  // Verdict and end of run
  task automatic stop_test;
    if (failures == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Push one command; a full queue holds it back
  task automatic push(input int s, input req_kind_t k, input logic b, input channel_selector_t c,
                      input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk) #1;
    cmd_word[s] = '{k, b, c, a, d};
    cmd_valid[s] = 1'b1;
    for (int n = 0; cmd_ready[s] !== 1'b1 && n < 500; n++) begin
      refused++;
      @(posedge mclk) #1;
    end
    @(posedge mclk) #1;
    cmd_valid[s] = 1'b0;
  endtask
  // Wait for read answer number k+1 and judge it
  task automatic rd_wait(input int k, input logic [17:0] exp);
    for (int n = 0; nrd <= k && n < 300; n++) @(posedge mclk) #1;
    `CHK(got, exp)
  endtask
  // Poll the memory view until the word settles
  task automatic mem_chk(input logic [3:0] a, input logic [15:0] d);
    peek_addr = a;
    for (int n = 0; peek_data !== d && n < 400; n++) @(posedge mclk) #1;
    `CHK(peek_data, d)
  endtask
  // Main sequence
  initial begin
    cmd_valid = '{1'b0, 1'b0};
    cmd_word = '{default: '0};
    peek_addr = 4'h0;
    repeat (2) @(posedge mclk);
    #1 rst_n = 1'b1;
    push(0, OP_WRITE, 1'b0, LOW_LATENCY_CHANNEL, 4'h3, 16'h1111);
    push(0, OP_WRITE, 1'b1, LOW_LATENCY_CHANNEL, 4'h3, 16'h2222);
    mem_chk(4'h3, 16'h2222);
    push(0, OP_READ, 1'b1, LOW_LATENCY_CHANNEL, 4'h3, 16'h0000);
    rd_wait(0, 18'h02222);
    push(1, OP_WRITE, 1'b0, HOST_LINK_CHANNEL_A, 4'h5, 16'hAAAA);
    push(1, OP_WRITE, 1'b1, HOST_LINK_CHANNEL_B, 4'h5, 16'hBBBB);
    mem_chk(4'h5, 16'hBBBB);
    // Read, then dependent write
    push(1, OP_READ, 1'b0, AUTO_SELECT_CHANNEL, 4'h5, 16'h0000);
    push(1, OP_WRITE, 1'b1, AUTO_SELECT_CHANNEL, 4'h5, 16'hCCCC);
    rd_wait(1, 18'h1BBBB);
    mem_chk(4'h5, 16'hCCCC);
    // Fences slow the drain, so the queue fills
    refused = 0;
    for (int i = 0; i < 40; i++) push(0, OP_WRITE, 1'b1, AUTO_SELECT_CHANNEL, 4'(i), 16'(i) + 16'h0100);
    `CHK(refused > 0, 1'b1)
    mem_chk(4'h7, 16'h0127);
    `CHK(fence_busy, 1'b0)
    `CHK(stalled, 2'b00)
    stop_test();
  end
  // Watchdog well beyond the expected run
  initial begin
    #(50 * 20000);
    failures++;
    stop_test();
  end
endmodule
`default_nettype wire
